// ===== logic/servo_fifo.sv
`timescale 1ns/1ps
module servo_fifo #(
   parameter int WIDTH = 11,
   parameter int DEPTH = 16
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];  // Storage
   logic [AW-1:0]    wr_ptr;       // Write index
   logic [AW-1:0]    rd_ptr;       // Read index
   logic [AW:0]      count;        // Words held
   wire              push = in_valid & in_ready;
   wire              pop  = out_valid & out_ready;
   wire [AW:0]       next_count = count + (AW+1)'(push) - (AW+1)'(pop);
   assign out_data = mem[rd_ptr];
   // Flags are registered from the next count so both stay honest
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr    <= '0;
         rd_ptr    <= '0;
         count     <= '0;
         in_ready  <= 1'b1;
         out_valid <= 1'b0;
      end else begin
         wr_ptr    <= push ? AW'(wr_ptr + 1'b1) : wr_ptr;
         rd_ptr    <= pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
         count     <= next_count;
         in_ready  <= next_count != (AW+1)'(DEPTH);
         out_valid <= next_count != '0;
      end
   end
   // Storage has no reset
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end
endmodule

// ===== logic/servo_node_command_unit.sv
`timescale 1ns/1ps
// Summary of operation
// - Command-only mode drops frames with ninth clear
// - Ninth-bit frames reach every node's decoder
// - Act only when command address matches own
// - Addressed poll opens reception to all frames
// - Opcodes: position, poll, up, down, stop
// - Position: four position, two velocity bytes
// - Poll answered with four position bytes
// - Event without received byte flags error, dropped
// - Ninth bit set is command, clear data
// - Addressed node echoes command; others silent
// - Position command opens reception to data
// - Buffer data, load targets, back to command-only
// - Manual flag forces constant PWM each tick
// - Up sets clockwise, down counter-clockwise
// - Manual runs until stop, limit or the last position data byte
// - Stop clears manual, target takes position
// - Velocity differential uses three past errors
// - Incremental velocity output, scaled to 16 bits
// - Decayed integral, halved error difference
// - Weighted sum at 32 bits, then scaled
// - Output sign selects direction, magnitude kept
// - PWM magnitude clamped to full scale
// - Position path at least 24 bits wide
// - Loop runs once per 500 us tick
// - Data error halts motor, replies FF; else 88
module servo_node_command_unit #(
   parameter int unsigned                    TICK_CYCLES = servo_pkg::TICK_CYCLES_DEFAULT,
   parameter logic [servo_pkg::ADDR_W-1:0]   NODE_ADDR   = servo_pkg::NODE_ADDR_DEFAULT
) (
   input  wire logic                                clk,
   input  wire logic                                rst_n,
   input  wire logic                                rx_valid,
   input  wire logic        [servo_pkg::DATA_W-1:0] rx_data,
   input  wire logic                                rx_ninth,
   input  wire logic                                receive_complete_flag,
   input  wire logic                                rx_frame_error,
   input  wire logic                                rx_overrun_error,
   output logic                                     rx_ready,
   output logic                                     accept_all_mode,
   output logic                                     tx_start,
   output logic             [servo_pkg::DATA_W-1:0] tx_data,
   input  wire logic                                tx_complete,
   input  wire logic        [servo_pkg::POS_W-1:0]  current_position,
   input  wire logic signed [servo_pkg::VEL_W-1:0]  velocity,
   input  wire logic                                limit_cw,
   input  wire logic                                limit_ccw,
   input  wire logic signed [servo_pkg::GAIN_W-1:0] proportional_gain,
   input  wire logic signed [servo_pkg::GAIN_W-1:0] integral_gain,
   input  wire logic signed [servo_pkg::GAIN_W-1:0] derivative_gain,
   output logic             [7:0]                   pwm_duty,
   output logic                                     direction_up,
   output logic                                     manual_mode,
   output logic                                     motor_halted,
   output logic                                     receive_error,
   output logic             [servo_pkg::POS_W-1:0]  target_position,
   output logic             [servo_pkg::VEL_W-1:0]  max_velocity
);
   import servo_pkg::*;

   // Receive side
   logic [FIFO_W-1:0] fifo_word;      // Oldest queued frame
   logic              fifo_valid;     // Frame waiting
   logic              fifo_in_ready;  // Room in queue
   logic              collecting;     // Taking position data
   logic [2:0]        rx_count;       // Data bytes so far
   logic              err_seen;       // Line error during data
   logic [7:0]        rx_buf [6];     // Position data buffer

   // Transmit side
   tx_state_t         tx_state;       // Sequencer state
   logic [7:0]        tx_buf [5];     // Outgoing bytes
   logic [2:0]        tx_left;        // Bytes not yet completed
   logic [2:0]        tx_idx;         // Next byte to send
   logic              poll_active;    // Reply belongs to a poll

   // Control tick
   logic [31:0]       tick_cnt;       // Cycles since last tick
   logic              tick;           // One-cycle tick pulse
   logic              pid_done;       // Loop result ready
   logic [7:0]        pid_mag;        // Loop magnitude
   logic              pid_dir;        // Loop direction

   // Only queue frames this node is meant to see: command-only mode
   // hides data frames entirely, so no event is raised
   wire rx_push = rx_valid & (rx_ninth | accept_all_mode);
   wire [FIFO_W-1:0] rx_word = {rx_frame_error | rx_overrun_error,
                                receive_complete_flag, rx_ninth, rx_data};

   // The decoder stalls while a reply is in flight, which backs the queue up
   wire proc_ready = (tx_left == 3'h0);
   wire take       = fifo_valid & proc_ready;

   // Fields of the frame being handled
   wire [7:0]        w_data  = fifo_word[7:0];
   wire              w_ninth = fifo_word[RXW_NINTH];
   wire              w_ok    = fifo_word[RXW_OK];
   wire              w_err   = fifo_word[RXW_ERR];

   // Event with no byte behind it is an error and goes no further
   wire bad_event = take & ~w_ok;
   // Classify by ninth bit
   wire is_cmd    = take & w_ok & w_ninth;
   wire is_data   = take & w_ok & ~w_ninth & collecting;

   // Command byte split into address and opcode
   wire [ADDR_W-1:0] cmd_addr = w_data[ADDR_LSB +: ADDR_W];
   wire opcode_t     cmd_op   = w_data[OP_W-1:0];
   // Foreign address: drop without any action
   wire for_me   = is_cmd & (cmd_addr == NODE_ADDR);
   // Opcode decode; undefined codes are echoed and end any data collection
   wire do_pos   = for_me & (cmd_op == OP_POSITION);
   wire do_poll  = for_me & (cmd_op == OP_POLL);
   wire do_up    = for_me & (cmd_op == OP_UP);
   wire do_down  = for_me & (cmd_op == OP_DOWN);
   wire do_stop  = for_me & (cmd_op == OP_STOP);

   // Sixth data byte closes the position frame
   wire last_data = is_data & (rx_count == DATA_LAST);
   wire data_bad  = err_seen | w_err;
   wire load_ok   = last_data & ~data_bad;
   wire load_bad  = last_data & data_bad;

   // Travel limit in the direction of manual motion
   wire limit_hit = manual_mode & (direction_up ? limit_cw : limit_ccw);

   // Any reply byte completing, and the final byte of a poll reply
   wire byte_done = (tx_state == TX_WAIT) & tx_complete;
   wire poll_done = byte_done & (tx_left == 3'h1) & poll_active;

   // Loop errors
   wire signed [POS_W-1:0] pos_err = POS_W'(target_position - current_position);
   wire signed [VEL_W-1:0] vel_err = VEL_W'($signed(max_velocity) - velocity);
   wire                    use_vel = max_velocity != '0;

   // Incoming frame queue
   servo_fifo #(
      .WIDTH (FIFO_W),
      .DEPTH (FIFO_DEPTH)
   ) rx_queue (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_valid  (rx_push),
      .in_ready  (fifo_in_ready),
      .in_data   (rx_word),
      .out_valid (fifo_valid),
      .out_ready (proc_ready),
      .out_data  (fifo_word)
   );
   // Registered inside the queue, so this is a flop output
   assign rx_ready = fifo_in_ready;

   // Control loop datapath; 32-bit position covers the 24-bit need
   servo_pid loop (
      .clk               (clk),
      .rst_n             (rst_n),
      .tick              (tick),
      .use_velocity      (use_vel),
      .pos_err           (pos_err),
      .vel_err           (vel_err),
      .proportional_gain (proportional_gain),
      .integral_gain     (integral_gain),
      .derivative_gain   (derivative_gain),
      .done              (pid_done),
      .pwm_mag           (pid_mag),
      .dir_up            (pid_dir)
   );

   // Reception mode and data collection
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         accept_all_mode <= 1'b0;
         collecting      <= 1'b0;
         rx_count        <= '0;
         err_seen        <= 1'b0;
      end else if (for_me) begin
         // Any addressed command resets collection; only position collects again
         collecting <= do_pos;
         rx_count   <= '0;
         err_seen   <= 1'b0;
         if (do_pos | do_poll) begin
            accept_all_mode <= 1'b1;
         end
      end else if (is_data) begin
         rx_count <= 3'(rx_count + 1'b1);
         err_seen <= data_bad;
         if (last_data) begin
            collecting      <= 1'b0;
            rx_count        <= '0;
            accept_all_mode <= 1'b0;
         end
      end else if (poll_done) begin
         // Poll reply finished; back to command-only
         accept_all_mode <= 1'b0;
      end
   end

   // Data bytes land in the buffer by arrival order
   always_ff @(posedge clk) begin
      if (is_data) begin
         rx_buf[rx_count] <= w_data;
      end
   end

   // Event error pulse
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         receive_error <= 1'b0;
      end else begin
         receive_error <= bad_event;
      end
   end

   // Manual flag and halt state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         manual_mode  <= 1'b0;
         motor_halted <= 1'b0;
      end else if (do_up | do_down) begin
         manual_mode  <= 1'b1;
         motor_halted <= 1'b0;
      end else if (do_stop | limit_hit) begin
         manual_mode <= 1'b0;
      end else if (last_data) begin
         // Either way manual ends; a bad frame also halts
         manual_mode  <= 1'b0;
         motor_halted <= data_bad;
      end
   end

   // Targets: loaded from buffer or frozen at the present position
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         target_position <= '0;
         max_velocity    <= '0;
      end else if (do_stop | limit_hit) begin
         target_position <= current_position;
      end else if (load_ok) begin
         // Little-endian: position first, velocity last
         target_position <= {rx_buf[3], rx_buf[2], rx_buf[1], rx_buf[0]};
         max_velocity    <= {w_data, rx_buf[4]};
      end
   end

   // Reply buffer: echo, optional position, or the frame verdict
   always_ff @(posedge clk) begin
      if (for_me) begin
         tx_buf[0] <= w_data;
         tx_buf[1] <= current_position[7:0];
         tx_buf[2] <= current_position[15:8];
         tx_buf[3] <= current_position[23:16];
         tx_buf[4] <= current_position[31:24];
      end else if (last_data) begin
         tx_buf[0] <= load_bad ? REPLY_ERR : REPLY_OK;
      end
   end

   // Poll ownership of the reply in flight
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         poll_active <= 1'b0;
      end else if (do_poll) begin
         poll_active <= 1'b1;
      end else if (poll_done) begin
         poll_active <= 1'b0;
      end
   end

   // Transmit sequencer: one byte per completion until none left
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_state <= TX_IDLE;
         tx_left  <= '0;
         tx_idx   <= '0;
         tx_start <= 1'b0;
         tx_data  <= '0;
      end else begin
         tx_start <= 1'b0;
         if (for_me) begin
            // Unaddressed nodes never reach here
            tx_left <= do_poll ? TX_POLL_CNT : TX_ECHO_CNT;
         end else if (last_data) begin
            tx_left <= TX_ECHO_CNT;
         end
         case (tx_state)
            TX_IDLE, TX_SEND: begin
               if (tx_left != 3'h0) begin
                  tx_start <= 1'b1;
                  tx_data  <= tx_buf[tx_idx];
                  tx_state <= TX_WAIT;
               end
            end
            TX_WAIT: begin
               // Next byte only after completion
               if (tx_complete) begin
                  tx_left <= 3'(tx_left - 1'b1);
                  if (tx_left == 3'h1) begin
                     tx_idx   <= '0;
                     tx_state <= TX_IDLE;
                  end else begin
                     tx_idx   <= 3'(tx_idx + 1'b1);
                     tx_state <= TX_SEND;
                  end
               end
            end
            default: begin
               tx_state <= TX_IDLE;
            end
         endcase
      end
   end

   // Sampling tick; counter free-runs so the loop rate is fixed
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt <= '0;
         tick     <= 1'b0;
      end else if (tick_cnt == 32'(TICK_CYCLES - 1)) begin
         tick_cnt <= '0;
         tick     <= 1'b1;
      end else begin
         tick_cnt <= tick_cnt + 32'h00000001;
         tick     <= 1'b0;
      end
   end

   // Direction: manual commands set it at once, else the loop's sign
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         direction_up <= 1'b1;
      end else if (do_up) begin
         direction_up <= 1'b1;
      end else if (do_down) begin
         direction_up <= 1'b0;
      end else if (pid_done & ~manual_mode) begin
         direction_up <= pid_dir;
      end
   end

   // PWM: halt wins, manual constant on tick, otherwise loop result
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pwm_duty <= '0;
      end else if (motor_halted) begin
         pwm_duty <= '0;
      end else if (tick & manual_mode) begin
         pwm_duty <= MANUAL_PWM;
      end else if (pid_done & ~manual_mode) begin
         pwm_duty <= pid_mag;
      end
   end
endmodule

// ===== logic/servo_pid.sv
`timescale 1ns/1ps
module servo_pid (
   input  wire logic                               clk,
   input  wire logic                               rst_n,
   input  wire logic                               tick,
   input  wire logic                               use_velocity,
   input  wire logic signed [servo_pkg::POS_W-1:0] pos_err,
   input  wire logic signed [servo_pkg::VEL_W-1:0] vel_err,
   input  wire logic signed [servo_pkg::GAIN_W-1:0] proportional_gain,
   input  wire logic signed [servo_pkg::GAIN_W-1:0] integral_gain,
   input  wire logic signed [servo_pkg::GAIN_W-1:0] derivative_gain,
   output logic                                    done,
   output logic             [7:0]                  pwm_mag,
   output logic                                    dir_up
);
   import servo_pkg::*;
   logic signed [31:0] sum_int;      // Position integral sum
   logic signed [31:0] pos_err1;     // Previous position error
   logic signed [31:0] prev_output;  // Velocity loop accumulator
   logic signed [31:0] ve1;          // Velocity error one back
   logic signed [31:0] ve2;          // Two back
   logic signed [31:0] ve3;          // Three back
   wire signed [31:0] kp = 32'(proportional_gain);
   wire signed [31:0] ki = 32'(integral_gain);
   wire signed [31:0] kd = 32'(derivative_gain);
   wire signed [31:0] ve = 32'(vel_err);
   // Position loop: decayed sum, halved difference, full 32-bit sum
   wire signed [31:0] next_sum = (sum_int + pos_err) / DECAY;
   wire signed [31:0] diff_p   = (pos_err - pos_err1) / POS_DIV;
   wire signed [31:0] out_p    = (kp * pos_err + ki * next_sum + kd * diff_p) / SCALER;
   // Velocity loop: incremental form with third-order difference
   wire signed [31:0] diff_v = ve - ve3 + VEL_K3 * ve1 - VEL_K3 * ve2;
   wire signed [31:0] inc_v  = ((ve - ve1) * kp + (ve + ve1) * ki + diff_v * kd) / SCALER;
   wire signed [31:0] out_v  = prev_output + inc_v;
   wire signed [15:0] out16  = 16'(out_v / OUT_SCALER);
   // Sign to direction and clamp to 8 bits
   wire [8:0] drive = use_velocity ? pwm_drive(32'(out16)) : pwm_drive(out_p);
   // Loop state moves only on the control tick
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sum_int     <= '0;
         pos_err1    <= '0;
         prev_output <= '0;
         ve1         <= '0;
         ve2         <= '0;
         ve3         <= '0;
         done        <= 1'b0;
         pwm_mag     <= '0;
         dir_up      <= 1'b1;
      end else begin
         done <= tick;
         if (tick) begin
            sum_int     <= next_sum;
            pos_err1    <= pos_err;
            ve3         <= ve2;
            ve2         <= ve1;
            ve1         <= ve;
            prev_output <= use_velocity ? out_v : prev_output;
            dir_up      <= drive[8];
            pwm_mag     <= drive[7:0];
         end
      end
   end
endmodule

// ===== logic/servo_pkg.sv
package servo_pkg;
   // Timing: control tick period and clock rate
   localparam int unsigned CLK_MHZ             = 200;
   localparam int unsigned TICK_US             = 500;
   localparam int unsigned TICK_CYCLES_DEFAULT = CLK_MHZ * TICK_US;
   // Widths
   localparam int DATA_W = 8;
   localparam int POS_W  = 32;
   localparam int VEL_W  = 16;
   localparam int GAIN_W = 16;
   // Receive FIFO shape and word layout
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_W     = 11;
   localparam int RXW_NINTH  = 8;
   localparam int RXW_OK     = 9;
   localparam int RXW_ERR    = 10;
   // Command byte layout: address in the top bits, opcode below
   localparam int ADDR_LSB = 5;
   localparam int ADDR_W   = 3;
   localparam int OP_W     = 5;
   localparam logic [ADDR_W-1:0] NODE_ADDR_DEFAULT = 3'h1;
   typedef logic [OP_W-1:0] opcode_t;
   localparam opcode_t OP_POSITION = 5'h01;
   localparam opcode_t OP_POLL     = 5'h05;
   localparam opcode_t OP_UP       = 5'h08;
   localparam opcode_t OP_DOWN     = 5'h09;
   localparam opcode_t OP_STOP     = 5'h10;
   // Data frame counts and replies
   localparam logic [2:0] DATA_LAST   = 3'h5;
   localparam logic [2:0] TX_ECHO_CNT = 3'h1;
   localparam logic [2:0] TX_POLL_CNT = 3'h5;
   localparam logic [7:0] REPLY_OK    = 8'h88;
   localparam logic [7:0] REPLY_ERR   = 8'hFF;
   localparam logic [7:0] PWM_MAX     = 8'hFF;
   localparam logic [7:0] MANUAL_PWM  = 8'hC0;
   // Loop scaling constants
   localparam logic signed [31:0] DECAY      = 32'sh00000002;
   localparam logic signed [31:0] POS_DIV    = 32'sh00000002;
   localparam logic signed [31:0] VEL_K3     = 32'sh00000003;
   localparam logic signed [31:0] SCALER     = 32'sh00000100;
   localparam logic signed [31:0] OUT_SCALER = 32'sh00000010;
   // Transmit sequencer states
   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_SEND = 2'b01,
      TX_WAIT = 2'b10
   } tx_state_t;
   // Sign picks direction, magnitude clamps to full scale; returns {up, mag}
   function automatic logic [8:0] pwm_drive(input logic signed [31:0] v);
      logic [31:0] m;
      m = v[31] ? 32'(-v) : 32'(v);
      return {~v[31], (m > 32'(PWM_MAX)) ? PWM_MAX : m[7:0]};
   endfunction
endpackage

// ===== tb/servo_master_model.sv
`timescale 1ns/1ps
module servo_master_model (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic tx_start,
   input  wire logic slow,
   output logic      tx_complete
);
   int left; // Cycles until the byte is out
   // One byte on the wire at a time; a slow line stalls the replies
   always @(negedge clk or negedge rst_n) begin
      if (!rst_n) begin
         left <= 0;
         tx_complete <= 1'b0;
      end else begin
         tx_complete <= (left == 1);
         if (tx_start)
            left <= slow ? 12 : 2;
         else if (left != 0)
            left <= left - 1;
      end
   end
endmodule

// ===== tb/servo_node_command_unit_tb.sv
`timescale 1ns/1ps
module servo_node_command_unit_tb;
   import servo_pkg::*;
   localparam int TK = 50; // Short tick keeps the run brief
   localparam logic [2:0] ME = 3'h1; // Own address
   logic clk = 0, rst_n = 0, rx_valid = 0, rx_ninth = 0, receive_complete_flag = 0;
   logic rx_frame_error = 0, rx_overrun_error = 0, limit_cw = 0, limit_ccw = 0;
   logic slow = 0, err_seen = 0, rx_ready, accept_all_mode, tx_start, tx_complete;
   logic direction_up, manual_mode, motor_halted, receive_error;
   logic [7:0] rx_data = 8'h00, tx_data, pwm_duty;
   logic [31:0] current_position = 32'h0, target_position;
   logic signed [15:0] velocity = 0, proportional_gain = 0;
   logic signed [15:0] integral_gain = 0, derivative_gain = 0;
   logic [15:0] max_velocity;
   int n_errors = 0, checks_done = 0, cyc = 0, n_tx = 0, seed = 32'h47e3;
   servo_node_command_unit #(.TICK_CYCLES(TK), .NODE_ADDR(ME)) dut_u (
      .clk, .rst_n, .rx_valid, .rx_data, .rx_ninth, .receive_complete_flag,
      .rx_frame_error, .rx_overrun_error, .rx_ready, .accept_all_mode, .tx_start,
      .tx_data, .tx_complete, .current_position, .velocity, .limit_cw, .limit_ccw,
      .proportional_gain, .integral_gain, .derivative_gain, .pwm_duty, .direction_up,
      .manual_mode, .motor_halted, .receive_error, .target_position, .max_velocity);
   servo_master_model far_u (.clk, .rst_n, .tx_start, .slow, .tx_complete);
   always #2.5 clk = ~clk;
   // Watchdog; counts sent bytes and holds the short error pulse
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (tx_start === 1'b1) n_tx <= n_tx + 1;
      if (receive_error === 1'b1) err_seen <= 1'b1;
      if (cyc == 20000) begin
         n_errors++;
         print_verdict();
      end
   end
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic send(input logic [7:0] b, input logic n, input logic ok, input logic fe);
      @(negedge clk);
      rx_data = b;
      rx_ninth = n;
      receive_complete_flag = ok;
      rx_frame_error = fe;
      rx_valid = 1;
      @(negedge clk);
      rx_valid = 0;
   endtask
   task automatic expect_tx(input logic [7:0] e);
      int i;
      i = 0;
      while (tx_start !== 1'b1 && i < 300) begin
         @(negedge clk);
         i++;
      end
      chk("tx_start", 1, tx_start);
      chk("tx_data", e, tx_data);
      @(negedge clk);
   endtask
   task automatic cmd(input logic [4:0] op);
      send({ME, op}, 1, 1, 0);
      expect_tx({ME, op});
   endtask
   // Position frame; bad picks the data byte with a line error, 6 for none
   task automatic position(input int bad);
      logic [7:0] d[6];
      cmd(OP_POSITION);
      chk("mode", 1, accept_all_mode);
      foreach (d[i]) begin
         d[i] = 8'($random(seed));
         send(d[i], 0, 1, i == bad);
      end
      expect_tx(bad < 6 ? REPLY_ERR : REPLY_OK);
      chk("halt", bad < 6, motor_halted);
      if (bad == 6) chk("tgt", {d[3], d[2], d[1], d[0]}, target_position);
      if (bad == 6) chk("vel", {d[5], d[4]}, max_velocity);
      chk("mode", 0, accept_all_mode);
   endtask
   task automatic print_verdict();
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      proportional_gain = 16'($random(seed) % 64);
      integral_gain = 16'($random(seed) % 16);
      derivative_gain = 16'($random(seed) % 16);
      velocity = 16'($random(seed) % 32);
      current_position = $random(seed);
      repeat (10) @(negedge clk);
      rst_n = 1;
      chk("ready", 1, rx_ready);
      chk("dir", 1, direction_up);
      send(8'hA5, 0, 1, 0);
      for (int a = 0; a < 8; a++)
         if (3'(a) != ME) send({3'(a), 5'($random(seed))}, 1, 1, 0);
      repeat (60) @(negedge clk);
      chk("ntx", 0, n_tx);
      chk("mode", 0, accept_all_mode);
      position(6);
      slow = 1;
      position(5);
      send({ME, OP_POLL}, 1, 0, 0);
      repeat (30) @(negedge clk);
      chk("err", 1, err_seen);
      chk("ntx", 4, n_tx);
      cmd(5'h1F);
      cmd(OP_POLL);
      chk("mode", 1, accept_all_mode);
      for (int i = 0; i < 4; i++) expect_tx(current_position[8*i +: 8]);
      repeat (20) @(negedge clk);
      chk("mode", 0, accept_all_mode);
      cmd(OP_UP);
      chk("man", 1, manual_mode);
      chk("dir", 1, direction_up);
      repeat (TK + 4) @(negedge clk);
      chk("pwm", MANUAL_PWM, pwm_duty);
      current_position = $random(seed);
      cmd(OP_STOP);
      chk("man", 0, manual_mode);
      chk("tgt", current_position, target_position);
      cmd(OP_DOWN);
      chk("dir", 0, direction_up);
      repeat (TK + 4) @(negedge clk);
      chk("pwm", MANUAL_PWM, pwm_duty);
      limit_ccw = 1;
      repeat (TK + 4) @(negedge clk);
      chk("man", 0, manual_mode);
      chk("tgt", current_position, target_position);
      print_verdict();
   end
endmodule

// ===== tb/servo_node_sva.sv
`timescale 1ns/1ps
module servo_node_sva
   import servo_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = 50
) (
   input wire logic              clk,
   input wire logic              rst_n,
   input wire logic              accept_all_mode,
   input wire logic              tx_start,
   input wire logic [DATA_W-1:0] tx_data,
   input wire logic              tx_complete,
   input wire logic [POS_W-1:0]  current_position,
   input wire logic              limit_ccw,
   input wire logic              direction_up,
   input wire logic [7:0]        pwm_duty,
   input wire logic              manual_mode,
   input wire logic              motor_halted,
   input wire logic [POS_W-1:0]  target_position
);
   localparam int TW = 2 * TICK_CYCLES + 4; // Two ticks plus pipeline slack
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Error reply byte leaving the node
   sequence s_err_reply;
      tx_start && tx_data == REPLY_ERR;
   endsequence
   a_tx_pulse: assert property (tx_start |=> !tx_start)
      else $error("tx_start too long");
   a_tx_data_hold: assert property (!tx_start |-> $stable(tx_data))
      else $error("tx_data moved");
   a_one_in_flight: assert property (tx_start |=> !tx_start until tx_complete)
      else $error("byte started early");
   // A limit may end manual motion before any tick loads the constant
   a_manual_pwm: assert property (
      $rose(manual_mode) |-> ##[1:TW] (pwm_duty == MANUAL_PWM || !manual_mode))
      else $error("no manual pwm");
   a_limit_stop: assert property (
      manual_mode && !direction_up && limit_ccw |-> ##[1:TW] !manual_mode)
      else $error("limit ignored");
   a_stop_target: assert property (
      $fell(manual_mode) && !$fell(accept_all_mode) && $stable(current_position) |-> ##[0:2]
      target_position == current_position)
      else $error("target not loaded");
   a_halt_pwm: assert property ($rose(motor_halted) |-> ##[0:TW] pwm_duty == 8'h00)
      else $error("halt keeps pwm");
   a_err_reply: assert property ($rose(motor_halted) |-> ##[0:4] s_err_reply)
      else $error("no error reply");
endmodule
bind servo_node_command_unit servo_node_sva #(.TICK_CYCLES(TICK_CYCLES)) sva_u (
   .clk, .rst_n, .tx_start, .tx_data, .tx_complete, .current_position, .limit_ccw,
   .accept_all_mode, .direction_up, .pwm_duty, .manual_mode, .motor_halted, .target_position);
